// [bascc_map.vh]
// register map, field positions, reset values and timing counts for the
// arbiter timeout, system-error disable and secondary clock gate block.
// assumes a 32-bit apb slave where byte address = 4 * register index.
//
// Operation
// - a granted master not starting within 16 clocks sets its timeout flag
// - timeout flags 3..0 stay set until software writes one to them
// - timeout register bits 7..4 read zero and ignore writes
// - all error-report disable bits reset to zero, every source enabled
// - bit 6 clear reports delayed-read retry timeout, set suppresses it
// - bit 5 clear reports delayed-write retry timeout, set suppresses it
// - bit 4 clear reports posted-write master abort, set suppresses it
// - bit 3 clear reports posted-write target abort, set suppresses it
// - bit 2 clear reports posted-write retry timeout, set suppresses it
// - bit 1 clear reports posted-write parity error, set suppresses it
// - disable register bits 7 and 0 read zero and are not writable
// - clock control bit 8 stops output 4 and holds it high
// - only code 11 stops outputs 0..3 high; other codes keep them running
// - fields at 1..0, 3..2, 5..4, 7..6 serve outputs 0, 1, 2, 3
// - clock control bits 15..9 read zero
// - clock control resets to zero, all five outputs running
// - with auto masking on, a timed-out line's request is ignored
`ifndef BASCC_MAP_VH
`define BASCC_MAP_VH

// register indices as printed; byte address is four times the index
`define BASCC_IDX_TMO_FLAGS   10'h063
`define BASCC_IDX_ERR_DIS     10'h064
`define BASCC_IDX_CLK_GATES   10'h068
`define BASCC_IDX_AUTO_MASK   10'h070

// writable bit masks
`define BASCC_TMO_FLAGS_MASK  8'h0f
`define BASCC_ERR_DIS_MASK    8'h7e
`define BASCC_CLK_GATES_MASK  16'h01ff

// reset values
`define BASCC_TMO_FLAGS_RST   8'h00
`define BASCC_ERR_DIS_RST     8'h00
`define BASCC_CLK_GATES_RST   16'h0000
`define BASCC_AUTO_MASK_RST   1'h0

// error-report disable bit positions
`define BASCC_DIS_DLY_RD_TMO  6
`define BASCC_DIS_DLY_WR_TMO  5
`define BASCC_DIS_PW_MABORT   4
`define BASCC_DIS_PW_TABORT   3
`define BASCC_DIS_PW_TMO      2
`define BASCC_DIS_PW_PERR     1

// clock gate field positions
`define BASCC_CLK4_BIT        8
`define BASCC_CLK_FIELD_W     2
`define BASCC_CLK_STOP_CODE   2'h3

// auto masking enable bit
`define BASCC_AUTO_MASK_BIT   0

// start timeout in clocks of the bus
`define BASCC_START_TMO_CLKS  16

// pclk cycles per secondary clock half period
`define BASCC_SEC_HALF_DIV    1

`endif

// [bascc_clk_gate.v]
// one glitch-free secondary clock output gate.
// assumes phase_en is a one-cycle pulse on pclk at every half period.
`timescale 1ns/100ps
`default_nettype none
module bascc_clk_gate (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // control
    input  wire phase_en,
    input  wire stop_req,
    // output
    output reg  clk_out
);

    // a low phase always completes to high; a high phase only falls when
    // running, so stopping parks high and restarting keeps a full high phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out <= 1'b0;
        end else if (phase_en) begin
            if (!clk_out) begin
                clk_out <= 1'b1;
            end else if (!stop_req) begin
                clk_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// [bascc_top.v]
// arbiter start timeout flags, primary system-error report gating and
// secondary clock output gates, reached over an apb3 slave.
// assumes grants and error events come from logic on pclk; the frame and
// request pins are asynchronous and pass a two-stage synchroniser.
`timescale 1ns/100ps
`default_nettype none
`include "bascc_map.vh"
module bascc_top #(
    parameter START_TMO = `BASCC_START_TMO_CLKS,
    parameter HALF_DIV  = `BASCC_SEC_HALF_DIV
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // secondary bus pins, active low
    input  wire        secondary_frame_n,
    input  wire        secondary_request_line_0_n,
    input  wire        secondary_request_line_1_n,
    input  wire        secondary_request_line_2_n,
    input  wire        secondary_request_line_3_n,
    // arbiter grants, active high
    input  wire [3:0]  secondary_grant,
    // requests passed on to the arbiter, active high
    output reg  [3:0]  honoured_request,
    // error events, one-cycle pulses
    input  wire        evt_dly_rd_tmo,
    input  wire        evt_dly_wr_tmo,
    input  wire        evt_pw_mabort,
    input  wire        evt_pw_tabort,
    input  wire        evt_pw_tmo,
    input  wire        evt_pw_perr,
    // primary system error, open drain, active low
    output wire        primary_system_error_out_o,
    output reg         primary_system_error_out_oe,
    // secondary clock outputs
    output wire        sec_clk_output_0,
    output wire        sec_clk_output_1,
    output wire        sec_clk_output_2,
    output wire        sec_clk_output_3,
    output wire        sec_clk_output_4
);

    // byte addresses from printed indices
    localparam [11:0] ADDR_TMO_FLAGS = {`BASCC_IDX_TMO_FLAGS, 2'b00};
    localparam [11:0] ADDR_ERR_DIS   = {`BASCC_IDX_ERR_DIS, 2'b00};
    localparam [11:0] ADDR_CLK_GATES = {`BASCC_IDX_CLK_GATES, 2'b00};
    localparam [11:0] ADDR_AUTO_MASK = {`BASCC_IDX_AUTO_MASK, 2'b00};

    localparam integer TMO_LAST_I  = START_TMO - 1;
    localparam integer HALF_LAST_I = HALF_DIV - 1;
    localparam [4:0]   TMO_LAST    = TMO_LAST_I[4:0];
    localparam [7:0]   HALF_LAST   = HALF_LAST_I[7:0];

    // registers
    reg  [7:0]  request_start_timeout_flags;
    reg  [7:0]  primary_error_report_disables;
    reg  [15:0] secondary_clock_output_gates;
    reg         auto_mask_enable;

    // synchronisers
    reg  [4:0]  pin_meta;
    reg  [4:0]  pin_sync;

    // timers, one per request line
    wire [3:0]  tmo_event;

    // bus decode
    reg         hit;
    reg  [31:0] next_prdata;
    wire        setup_ph;
    wire        access_ph;
    wire        wr_en;

    // clock divider
    reg  [7:0]  half_cnt;
    reg         phase_en;
    wire [4:0]  stop_req;

    // error reporting
    wire        report_any;

    // derived pin views
    wire        frame_idle;
    wire [3:0]  req_active;

    // ---------------------------------------------------------------
    // pin synchronisers; only the second stage is read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
        end else begin
            pin_meta <= {secondary_request_line_3_n,
                         secondary_request_line_2_n,
                         secondary_request_line_1_n,
                         secondary_request_line_0_n,
                         secondary_frame_n};
            pin_sync <= pin_meta;
        end
    end

    assign frame_idle = pin_sync[0];
    assign req_active = ~pin_sync[4:1];

    // ---------------------------------------------------------------
    // start timers: count clocks granted with no frame; fire once on
    // the clock that completes the timeout, then saturate
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_tmr
            // local state per line keeps every register on one process
            reg [4:0] start_cnt;
            reg       fire;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    start_cnt <= 5'h00;
                    fire      <= 1'b0;
                end else if (secondary_grant[gi] && frame_idle) begin
                    if (start_cnt == TMO_LAST) begin
                        fire      <= 1'b1;
                        start_cnt <= start_cnt + 5'h01;
                    end else if (start_cnt < TMO_LAST) begin
                        fire      <= 1'b0;
                        start_cnt <= start_cnt + 5'h01;
                    end else begin
                        fire      <= 1'b0;
                    end
                end else begin
                    start_cnt <= 5'h00;
                    fire      <= 1'b0;
                end
            end
            assign tmo_event[gi] = fire;
        end
    endgenerate

    // ---------------------------------------------------------------
    // apb decode; zero wait states, read data captured in setup phase
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign pready    = 1'b1;
    assign pslverr   = access_ph && !hit;
    assign wr_en     = access_ph && pwrite && hit;

    always @* begin
        hit         = 1'b1;
        next_prdata = 32'h00000000;
        if (paddr == ADDR_TMO_FLAGS) begin
            next_prdata[7:0] = request_start_timeout_flags
                             & `BASCC_TMO_FLAGS_MASK;
        end else if (paddr == ADDR_ERR_DIS) begin
            next_prdata[7:0] = primary_error_report_disables
                             & `BASCC_ERR_DIS_MASK;
        end else if (paddr == ADDR_CLK_GATES) begin
            next_prdata[15:0] = secondary_clock_output_gates
                              & `BASCC_CLK_GATES_MASK;
        end else if (paddr == ADDR_AUTO_MASK) begin
            next_prdata[`BASCC_AUTO_MASK_BIT] = auto_mask_enable;
        end else begin
            hit = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ---------------------------------------------------------------
    // timeout flags: write one clears, a new timeout wins over the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_start_timeout_flags <= `BASCC_TMO_FLAGS_RST;
        end else begin
            request_start_timeout_flags <=
                ((request_start_timeout_flags
                  & ~((wr_en && paddr == ADDR_TMO_FLAGS) ?
                      pwdata[7:0] : 8'h00))
                 | {4'h0, tmo_event})
                & `BASCC_TMO_FLAGS_MASK;
        end
    end

    // ---------------------------------------------------------------
    // plain read/write registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_error_report_disables <= `BASCC_ERR_DIS_RST;
            secondary_clock_output_gates  <= `BASCC_CLK_GATES_RST;
            auto_mask_enable              <= `BASCC_AUTO_MASK_RST;
        end else if (wr_en) begin
            if (paddr == ADDR_ERR_DIS) begin
                primary_error_report_disables <= pwdata[7:0]
                    & `BASCC_ERR_DIS_MASK;
            end else if (paddr == ADDR_CLK_GATES) begin
                secondary_clock_output_gates <= pwdata[15:0]
                    & `BASCC_CLK_GATES_MASK;
            end else if (paddr == ADDR_AUTO_MASK) begin
                auto_mask_enable <= pwdata[`BASCC_AUTO_MASK_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // automatic request masking; a flagged line stays masked until
    // software clears its flag, so a stuck master cannot hog the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            honoured_request <= 4'h0;
        end else begin
            honoured_request <= req_active
                & ~({4{auto_mask_enable}}
                    & request_start_timeout_flags[3:0]);
        end
    end

    // ---------------------------------------------------------------
    // primary system error: low for one clock after each clock with any enabled event
    assign report_any =
        (evt_dly_rd_tmo &&
         !primary_error_report_disables[`BASCC_DIS_DLY_RD_TMO]) ||
        (evt_dly_wr_tmo &&
         !primary_error_report_disables[`BASCC_DIS_DLY_WR_TMO]) ||
        (evt_pw_mabort &&
         !primary_error_report_disables[`BASCC_DIS_PW_MABORT]) ||
        (evt_pw_tabort &&
         !primary_error_report_disables[`BASCC_DIS_PW_TABORT]) ||
        (evt_pw_tmo &&
         !primary_error_report_disables[`BASCC_DIS_PW_TMO]) ||
        (evt_pw_perr &&
         !primary_error_report_disables[`BASCC_DIS_PW_PERR]);

    assign primary_system_error_out_o = 1'b0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_system_error_out_oe <= 1'b0;
        end else begin
            primary_system_error_out_oe <= report_any;
        end
    end

    // ---------------------------------------------------------------
    // secondary clock half-period divider
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt <= 8'h00;
            phase_en <= 1'b0;
        end else if (half_cnt == HALF_LAST) begin
            half_cnt <= 8'h00;
            phase_en <= 1'b1;
        end else begin
            half_cnt <= half_cnt + 8'h01;
            phase_en <= 1'b0;
        end
    end

    // stop decode: only the all-ones code stops outputs 0..3
    genvar ci;
    generate
        for (ci = 0; ci < 4; ci = ci + 1) begin : g_stop
            assign stop_req[ci] = (secondary_clock_output_gates
                [ci*`BASCC_CLK_FIELD_W +: `BASCC_CLK_FIELD_W]
                == `BASCC_CLK_STOP_CODE);
        end
    endgenerate

    assign stop_req[4] = secondary_clock_output_gates[`BASCC_CLK4_BIT];

    // ---------------------------------------------------------------
    // clock gates; one instance per output
    bascc_clk_gate u_gate0 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_en (phase_en),
        .stop_req (stop_req[0]),
        .clk_out  (sec_clk_output_0)
    );

    bascc_clk_gate u_gate1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_en (phase_en),
        .stop_req (stop_req[1]),
        .clk_out  (sec_clk_output_1)
    );

    bascc_clk_gate u_gate2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_en (phase_en),
        .stop_req (stop_req[2]),
        .clk_out  (sec_clk_output_2)
    );

    bascc_clk_gate u_gate3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_en (phase_en),
        .stop_req (stop_req[3]),
        .clk_out  (sec_clk_output_3)
    );

    bascc_clk_gate u_gate4 (
        .pclk     (pclk),
        .presetn  (presetn),
        .phase_en (phase_en),
        .stop_req (stop_req[4]),
        .clk_out  (sec_clk_output_4)
    );

endmodule
`default_nettype wire

// [bascc_monitor.sv]
// checker for the bascc register block: error reports, clock gates, reads
// assumes a bind onto bascc_top; shadows disables and gates from apb writes
`timescale 1ns/100ps
`default_nettype none
module bascc_monitor #(
    parameter START_TMO = 16,
    parameter HALF_DIV  = 1
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // events and outputs
    input wire logic        evt_dly_rd_tmo,
    input wire logic        evt_dly_wr_tmo,
    input wire logic        evt_pw_mabort,
    input wire logic        evt_pw_tabort,
    input wire logic        evt_pw_tmo,
    input wire logic        evt_pw_perr,
    input wire logic        primary_system_error_out_oe,
    input wire logic        sec_clk_output_0,
    input wire logic        sec_clk_output_4
);
    logic [6:1] dis;
    logic [8:0] gate;
    logic [6:1] ev;
    logic       wr;
    logic       rd;
    assign ev = {evt_dly_rd_tmo, evt_dly_wr_tmo, evt_pw_mabort,
                 evt_pw_tabort, evt_pw_tmo, evt_pw_perr};
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    // shadows update on the same edge as the design, so old values apply
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis  <= 6'h0;
            gate <= 9'h0;
        end else if (wr && paddr == 12'h190) begin
            dis  <= pwdata[6:1];
        end else if (wr && paddr == 12'h1a0) begin
            gate <= pwdata[8:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_high_a: assert property (pready)
        else $error("pready low");
    serr_report_a: assert property (
        |(ev & ~dis) |=> primary_system_error_out_oe)
        else $error("enabled event gave no error report");
    serr_quiet_a: assert property (
        !(|(ev & ~dis)) |=> !primary_system_error_out_oe)
        else $error("error report without enabled event");
    clk4_hold_a: assert property (
        gate[8] && $past(gate[8]) && sec_clk_output_4 |=> sec_clk_output_4)
        else $error("stopped clock 4 left high level");
    clk0_hold_a: assert property (
        gate[1:0] == 2'h3 && $past(gate[1:0]) == 2'h3 && sec_clk_output_0
        |=> sec_clk_output_0)
        else $error("stopped clock 0 left high level");
    clk0_run_a: assert property (
        ((HALF_DIV == 1) && gate[1:0] != 2'h3) [*3]
        |-> sec_clk_output_0 != $past(sec_clk_output_0))
        else $error("running clock 0 did not toggle");
    flags_rsvd_a: assert property (
        rd && paddr == 12'h18c |-> prdata[31:4] == 28'h0)
        else $error("timeout flag upper bits not zero");
    dis_rsvd_a: assert property (
        rd && paddr == 12'h190 |-> prdata[31:7] == 25'h0 && !prdata[0])
        else $error("disable reserved bits not zero");
    gates_rsvd_a: assert property (
        rd && paddr == 12'h1a0 |-> prdata[31:9] == 23'h0)
        else $error("clock gate upper bits not zero");
    cover property (ev[1] && !dis[1]);
    cover property (gate[8] && sec_clk_output_4);
    cover property (rd && paddr == 12'h18c && prdata[0]);
endmodule
bind bascc_top bascc_monitor #(.START_TMO(START_TMO), .HALF_DIV(HALF_DIV))
    mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
         .pready, .prdata, .evt_dly_rd_tmo, .evt_dly_wr_tmo, .evt_pw_mabort,
         .evt_pw_tabort, .evt_pw_tmo, .evt_pw_perr,
         .primary_system_error_out_oe, .sec_clk_output_0, .sec_clk_output_4);
`default_nettype wire

// [bascc_sec_masters.sv]
// behavioural secondary bus masters: four request pins and a shared frame
// assumes grants on pclk; a lazy master never starts its granted cycle
`timescale 1ns/100ps
`default_nettype none
module bascc_sec_masters (
    // clock
    input  wire logic       pclk,
    // control from the bench
    input  wire logic [3:0] want,
    input  wire logic       lazy,
    input  wire logic [3:0] grant,
    // pins, active low
    output var  logic [3:0] req_n,
    output var  logic       frame_n
);
    initial begin
        req_n   = 4'hf;
        frame_n = 1'b1;
    end
    // frame has a pull-up, so released means high, never the old value
    always @(posedge pclk) begin
        req_n   <= ~want;
        frame_n <= ~(|grant & ~lazy);
    end
endmodule
`default_nettype wire

// [tb_bridge_arb_serr_clock_ctrl.sv]
// self-checking bench for bascc_top with a model of flags and disables
// assumes HALF_DIV 1 so a running output toggles every pclk
`timescale 1ns/100ps
`default_nettype none
module tb_bridge_arb_serr_clock_ctrl;
    logic        pclk, presetn, psel, penable, pwrite, lazy, last_err;
    logic        pready, pslverr, oe, serr_o, frame_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  grant, want, req_n, honoured;
    logic [6:1]  evt;
    logic [4:0]  sclk, s1;
    wire         serr_pin_n;
    integer      n_errors, comparisons, flags, dis, g, i, k, stop;
    // open-drain pin with pull-up
    assign serr_pin_n = oe ? serr_o : 1'b1;
    bascc_top #(.START_TMO(16), .HALF_DIV(1)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .secondary_frame_n(frame_n),
        .secondary_request_line_0_n(req_n[0]),
        .secondary_request_line_1_n(req_n[1]),
        .secondary_request_line_2_n(req_n[2]),
        .secondary_request_line_3_n(req_n[3]),
        .secondary_grant(grant), .honoured_request(honoured),
        .evt_dly_rd_tmo(evt[6]), .evt_dly_wr_tmo(evt[5]),
        .evt_pw_mabort(evt[4]), .evt_pw_tabort(evt[3]),
        .evt_pw_tmo(evt[2]), .evt_pw_perr(evt[1]),
        .primary_system_error_out_o(serr_o),
        .primary_system_error_out_oe(oe),
        .sec_clk_output_0(sclk[0]), .sec_clk_output_1(sclk[1]),
        .sec_clk_output_2(sclk[2]), .sec_clk_output_3(sclk[3]),
        .sec_clk_output_4(sclk[4]));
    bascc_sec_masters masters (.pclk(pclk), .want(want), .lazy(lazy),
        .grant(grant), .req_n(req_n), .frame_n(frame_n));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 16);
            if (pready !== 1'b1) begin
                n_errors = n_errors + 1;
                final_report;
            end
            rd       = prdata;
            last_err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr_rd(input logic [11:0] a, input logic [31:0] d,
               input logic [31:0] exp);
        begin
            apb(1'b1, a, d);
            apb(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    // a lazy master holds grant with frame idle; prompt one starts at once
    task tmo(input integer line, input integer len, input logic lz,
             input integer hit);
        begin
            lazy  <= lz;
            grant <= 4'h1 << line;
            repeat (len) @(posedge pclk);
            grant <= 4'h0;
            repeat (3) @(posedge pclk);
            if (hit)
                flags = flags | (1 << line);
            apb(1'b0, 12'h18c, 32'h0);
            chk(rd, flags);
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        lazy = 1'b1;
        grant = 4'h0;
        want = 4'hf;
        evt = 6'h0;
        flags = 0;
        n_errors = 0;
        comparisons = 0;
        void'($urandom(46176));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h18c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h190, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h1a0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h1c4, 32'h0);
        chk(last_err, 32'h1);
        chk(rd, 32'h0);
        wr_rd(12'h190, 32'hffffffff, 32'h7e);
        wr_rd(12'h1a0, 32'hffffffff, 32'h1ff);
        wr_rd(12'h18c, 32'hffffffff, 32'h0);
        $display("test registers done");
        for (k = 0; k < 3; k++) begin
            dis = (k == 0) ? 0 : (k == 1) ? 8'h7e : $urandom & 8'h7e;
            wr_rd(12'h190, dis, dis);
            for (i = 1; i < 7; i++) begin
                @(posedge pclk);
                evt <= 6'h1 << (i - 1);
                @(posedge pclk);
                evt <= 6'h0;
                #1;
                chk(serr_pin_n, dis[i] ? 1 : 0);
            end
        end
        $display("test error reports done");
        for (i = 0; i < 4; i++) begin
            tmo(i, 12, 1'b1, 0);
            tmo(i, 24, 1'b0, 0);
            tmo(i, 24, 1'b1, 1);
            wr_rd(12'h18c, 32'h0, flags);
        end
        for (i = 0; i < 4; i++) begin
            flags = flags & ~(1 << i);
            wr_rd(12'h18c, 32'hf0 | (1 << i), flags);
        end
        // clearing write lands on the edge at which line 1 times out
        lazy  <= 1'b1;
        grant <= 4'h2;
        repeat (14) @(posedge pclk);
        apb(1'b1, 12'h18c, 32'h2);
        grant <= 4'h0;
        apb(1'b0, 12'h18c, 32'h0);
        chk(rd, 32'h2);
        wr_rd(12'h18c, 32'h2, 32'h0);
        wr_rd(12'h1c0, 32'h1, 32'h1);
        tmo(2, 24, 1'b1, 1);
        chk(honoured, 4'hb);
        flags = 0;
        wr_rd(12'h18c, 32'h4, 32'h0);
        repeat (3) @(posedge pclk);
        chk(honoured, 4'hf);
        $display("test timeouts done");
        for (k = 0; k < 8; k++) begin
            g = (k == 0) ? 9'h1e4 : $urandom & 9'h1ff;
            wr_rd(12'h1a0, g, g);
            repeat (4) @(posedge pclk);
            #1;
            s1 = sclk;
            @(posedge pclk);
            #1;
            for (i = 0; i < 5; i++) begin
                stop = (i == 4) ? g[8] : (g[2*i+:2] == 2'h3);
                chk(stop ? s1[i] & sclk[i] : s1[i] ^ sclk[i], 1);
            end
        end
        $display("test clock gates done");
        final_report;
    end
endmodule
`default_nettype wire
